/* common/ipl_pkg.sv */
// Shared constants and types for the address select and status indicator block
package ipl_pkg;

  // Fixed address prefix and mask for switch-selected addressing
  localparam logic [23:0] FIXED_PREFIX   = 24'hC0A801;     // 192.168.1
  localparam logic [31:0] FIXED_MASK     = 32'hFFFFFF00;   // 255.255.255.0
  localparam logic [7:0]  SW_DHCP_WAIT   = 8'h00;          // Switch value: ask DHCP
  localparam logic [7:0]  SW_DHCP_FORCE  = 8'hFF;          // Switch value: DHCP always

  // Blink and self-test timing
  localparam int          CLK_HZ         = 20_000_000;     // System clock rate
  localparam int          SLOW_BLINK_MS  = 500;            // Half period, slow flash
  localparam int          FAST_BLINK_MS  = 100;            // Half period, flicker
  localparam int          SELFTEST_MS    = 2000;           // Self-test duration
  localparam int          SLOW_CYC       = CLK_HZ / 1000 * SLOW_BLINK_MS;
  localparam int          FAST_CYC       = CLK_HZ / 1000 * FAST_BLINK_MS;
  localparam int          SELFTEST_CYC   = CLK_HZ / 1000 * SELFTEST_MS;

  // Reset values
  localparam logic        DHCP_EN_RST    = 1'b1;           // Delivered with DHCP on

  // Address source
  typedef enum logic [2:0] {
    SRC_NONE    = 3'b000,
    SRC_SWITCH  = 3'b001,
    SRC_DHCP    = 3'b010,
    SRC_STORED  = 3'b011,
    SRC_WAIT    = 3'b100
  } ipl_src_t;

  // Sequencer phase
  typedef enum logic [1:0] {
    PH_INIT     = 2'b00,
    PH_TEST     = 2'b01,
    PH_RUN      = 2'b10
  } ipl_phase_t;

  // Two-colour indicator: green and red/orange
  typedef struct packed {
    logic       green;
    logic       red;
  } ipl_led_t;

  // Address configuration as applied
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] mask;
    logic        valid;
    logic        dhcp_active;
    ipl_src_t    src;
  } ipl_addr_t;

  // Port link status
  typedef struct packed {
    logic       link;
    logic       fast;
    logic       activity;
  } ipl_port_t;

endpackage : ipl_pkg

/* hw/ipl_top.sv */
// Address source selection and status indicator driver
`timescale 1ns/10ps
module ipl_top #(
  parameter int SLOW_CYCLES     = ipl_pkg::SLOW_CYC,      // Slow flash half period
  parameter int FAST_CYCLES     = ipl_pkg::FAST_CYC,      // Flicker half period
  parameter int SELFTEST_CYCLES = ipl_pkg::SELFTEST_CYC   // Self-test length
) (
  // Clock and reset
  input  wire logic             CLK_SYS,
  input  wire logic             SYS_RST,
  // Address switch, position one is bit 7
  input  wire logic [7:0]       ADDR_SWITCH,
  // DHCP client result
  input  wire logic             DHCP_DONE,
  input  wire logic [31:0]      DHCP_ADDR,
  input  wire logic [31:0]      DHCP_MASK,
  // Scanner address assignment, one-cycle strobe
  input  wire logic             SCANNER_SET,
  // Web server address assignment, one-cycle strobe
  input  wire logic             WEB_SET,
  // Shared data for both assignments
  input  wire logic [31:0]      SET_ADDR,
  input  wire logic [31:0]      SET_MASK,
  // Module and connection status
  input  wire logic             CONFIGURED,
  input  wire logic             MINOR_FAULT,
  input  wire logic             MAJOR_FAULT,
  input  wire logic             CONN_UP,
  input  wire logic             CONN_LOST,
  input  wire logic             ADDR_CONFLICT,
  // Ethernet port status
  input  wire ipl_pkg::ipl_port_t FIRST_ETHERNET_PORT,
  input  wire ipl_pkg::ipl_port_t SECOND_ETHERNET_PORT,
  // Applied address configuration
  output ipl_pkg::ipl_addr_t    ADDR_CFG,
  output logic                  DHCP_REQUEST,
  output logic                  NET_START,
  // Indicators
  output ipl_pkg::ipl_led_t     MODULE_STATE_INDICATOR,
  output ipl_pkg::ipl_led_t     NETWORK_STATE_INDICATOR,
  output ipl_pkg::ipl_led_t     PORT1_LINK_ACTIVITY_INDICATOR,
  output ipl_pkg::ipl_led_t     PORT2_LINK_ACTIVITY_INDICATOR
);

  // Whole module state
  typedef struct packed {
    ipl_pkg::ipl_phase_t phase;      // Power-up sequencer
    logic [7:0]          sw;         // Switch captured at power-up
    logic                dhcp_en;    // Dynamic acquisition enabled
    logic                stored_ok;  // Network-assigned address held
    logic [31:0]         stored_addr;
    logic [31:0]         stored_mask;
    logic                dhcp_ok;    // DHCP address held
    logic [31:0]         dhcp_addr;
    logic [31:0]         dhcp_mask;
    logic [31:0]         test_cnt;   // Self-test timer
    logic [31:0]         slow_cnt;   // Slow flash divider
    logic                slow;       // Slow flash phase
    logic [31:0]         fast_cnt;   // Flicker divider
    logic                fast;       // Flicker phase
    ipl_pkg::ipl_addr_t  cfg;        // Applied address
    ipl_pkg::ipl_led_t   ms;
    ipl_pkg::ipl_led_t   ns;
    ipl_pkg::ipl_led_t   la1;
    ipl_pkg::ipl_led_t   la2;
  } ipl_state_t;

  ipl_state_t st;                    // Registered state
  ipl_state_t next_st;               // Next state

  // Link indicator: colour by speed, flicker on traffic
  function automatic ipl_pkg::ipl_led_t link_led(input ipl_pkg::ipl_port_t p, input logic fl);
    ipl_pkg::ipl_led_t l;
    logic              on;
    on      = p.link & ~(p.activity & fl);
    l.green = on;
    l.red   = on & ~p.fast;                                       // Orange is green plus red
    return l;
  endfunction

  // Next-state logic
  always_comb begin
    next_st = st;

    // Free-running blink dividers
    if (st.slow_cnt >= 32'(SLOW_CYCLES - 1)) begin
      next_st.slow_cnt = 32'h0000_0000;
      next_st.slow     = ~st.slow;
    end else begin
      next_st.slow_cnt = st.slow_cnt + 32'h0000_0001;
    end
    if (st.fast_cnt >= 32'(FAST_CYCLES - 1)) begin
      next_st.fast_cnt = 32'h0000_0000;
      next_st.fast     = ~st.fast;
    end else begin
      next_st.fast_cnt = st.fast_cnt + 32'h0000_0001;
    end

    case (st.phase)
      // Capture switch once, no command needed
      ipl_pkg::PH_INIT: begin
        next_st.sw       = ADDR_SWITCH;
        next_st.test_cnt = 32'h0000_0000;
        next_st.phase    = ipl_pkg::PH_TEST;
      end
      // Self-test, then start network
      ipl_pkg::PH_TEST: begin
        if (st.test_cnt >= 32'(SELFTEST_CYCLES - 1)) begin
          next_st.phase = ipl_pkg::PH_RUN;
        end else begin
          next_st.test_cnt = st.test_cnt + 32'h0000_0001;
        end
      end
      ipl_pkg::PH_RUN: begin
        next_st.phase = ipl_pkg::PH_RUN;
      end
      default: begin
        next_st.phase = ipl_pkg::PH_INIT;
      end
    endcase

    // DHCP enable follows the captured switch, settled before the run phase
    // so a fixed address never raises a stray request at start-up
    if (st.phase != ipl_pkg::PH_INIT) begin
      if (st.sw == ipl_pkg::SW_DHCP_FORCE) begin
        next_st.dhcp_en   = 1'b1;
        next_st.stored_ok = 1'b0;                                 // Stored setting ignored
      end else if (st.sw != ipl_pkg::SW_DHCP_WAIT) begin
        next_st.dhcp_en   = 1'b0;
      end
    end

    // Address assignments from the network side
    if (st.phase == ipl_pkg::PH_RUN) begin
      if (SCANNER_SET && st.sw == ipl_pkg::SW_DHCP_WAIT && st.dhcp_en) begin
        next_st.stored_ok   = 1'b1;
        next_st.stored_addr = SET_ADDR;
        next_st.stored_mask = SET_MASK;
      end else if (WEB_SET && st.sw != ipl_pkg::SW_DHCP_FORCE) begin
        next_st.stored_ok   = 1'b1;
        next_st.stored_addr = SET_ADDR;
        next_st.stored_mask = SET_MASK;
      end
      // DHCP result latched only while dynamic acquisition runs
      if (DHCP_DONE && st.dhcp_en) begin
        next_st.dhcp_ok   = 1'b1;
        next_st.dhcp_addr = DHCP_ADDR;
        next_st.dhcp_mask = DHCP_MASK;
      end
    end

    // Address source selection
    next_st.cfg = '0;
    next_st.cfg.dhcp_active = next_st.dhcp_en;                    // Same edge as the source
    next_st.cfg.src         = ipl_pkg::SRC_NONE;
    if (st.phase == ipl_pkg::PH_RUN) begin
      if (st.sw != ipl_pkg::SW_DHCP_WAIT && st.sw != ipl_pkg::SW_DHCP_FORCE) begin
        next_st.cfg.addr  = {ipl_pkg::FIXED_PREFIX, st.sw};
        next_st.cfg.mask  = ipl_pkg::FIXED_MASK;
        next_st.cfg.valid = 1'b1;
        next_st.cfg.src   = ipl_pkg::SRC_SWITCH;
      end else if (st.stored_ok && st.sw != ipl_pkg::SW_DHCP_FORCE) begin
        next_st.cfg.addr  = st.stored_addr;
        next_st.cfg.mask  = st.stored_mask;
        next_st.cfg.valid = 1'b1;
        next_st.cfg.src   = ipl_pkg::SRC_STORED;
      end else if (st.dhcp_ok) begin
        next_st.cfg.addr  = st.dhcp_addr;
        next_st.cfg.mask  = st.dhcp_mask;
        next_st.cfg.valid = 1'b1;
        next_st.cfg.src   = ipl_pkg::SRC_DHCP;
      end else begin
        next_st.cfg.src   = ipl_pkg::SRC_WAIT;                    // Waiting for server
      end
    end

    // Indicators
    if (st.phase != ipl_pkg::PH_RUN) begin
      // Both alternate green and red together
      next_st.ms = '{green: ~st.slow, red: st.slow};
      next_st.ns = '{green: ~st.slow, red: st.slow};
    end else begin
      // Module state, major fault takes priority
      if (MAJOR_FAULT) begin
        next_st.ms = '{green: 1'b0, red: 1'b1};                   // Steady red
      end else if (MINOR_FAULT) begin
        next_st.ms = '{green: 1'b0, red: st.slow};                // Flashing red
      end else if (!CONFIGURED) begin
        next_st.ms = '{green: st.slow, red: 1'b0};                // Flashing green
      end else begin
        next_st.ms = '{green: 1'b1, red: 1'b0};                   // Steady green
      end
      // Network state, conflict outranks lost connection
      if (!next_st.cfg.valid) begin
        next_st.ns = '{green: 1'b0, red: 1'b0};
      end else if (ADDR_CONFLICT) begin
        next_st.ns = '{green: 1'b0, red: 1'b1};                   // Steady red
      end else if (CONN_LOST) begin
        next_st.ns = '{green: 1'b0, red: st.slow};                // Flashing red
      end else if (CONN_UP) begin
        next_st.ns = '{green: 1'b1, red: 1'b0};                   // Steady green
      end else begin
        next_st.ns = '{green: st.slow, red: 1'b0};                // Flashing green
      end
    end
    next_st.la1 = link_led(FIRST_ETHERNET_PORT, st.fast);
    next_st.la2 = link_led(SECOND_ETHERNET_PORT, st.fast);
  end

  // State register; DHCP on after reset
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      st         <= '0;
      st.phase   <= ipl_pkg::PH_INIT;
      st.dhcp_en <= ipl_pkg::DHCP_EN_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state
  assign ADDR_CFG                      = st.cfg;
  assign DHCP_REQUEST                  = (st.phase == ipl_pkg::PH_RUN) & st.dhcp_en & ~st.dhcp_ok;
  assign NET_START                     = (st.phase == ipl_pkg::PH_RUN);
  assign MODULE_STATE_INDICATOR        = st.ms;
  assign NETWORK_STATE_INDICATOR       = st.ns;
  assign PORT1_LINK_ACTIVITY_INDICATOR = st.la1;
  assign PORT2_LINK_ACTIVITY_INDICATOR = st.la2;

endmodule // ipl_top

/* tb/ipl_properties.sv */
// Concurrent checks on the address select and indicator outputs
`timescale 1ns/10ps
module ipl_properties (
  // Clock and reset
  input wire logic               CLK_SYS,
  input wire logic               SYS_RST,
  // Watched inputs
  input wire logic               MAJOR_FAULT,
  input wire logic               ADDR_CONFLICT,
  input wire ipl_pkg::ipl_port_t FIRST_ETHERNET_PORT,
  // Watched outputs
  input wire ipl_pkg::ipl_addr_t ADDR_CFG,
  input wire logic               DHCP_REQUEST,
  input wire logic               NET_START,
  input wire ipl_pkg::ipl_led_t  MODULE_STATE_INDICATOR,
  input wire ipl_pkg::ipl_led_t  NETWORK_STATE_INDICATOR,
  input wire ipl_pkg::ipl_led_t  PORT1_LINK_ACTIVITY_INDICATOR
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // Run phase already in force one cycle back
  sequence run_s; NET_START ##0 $past(NET_START); endsequence
  // Both state lamps lit alike, one colour at a time
  sequence alt_s; (MODULE_STATE_INDICATOR == NETWORK_STATE_INDICATOR && ^MODULE_STATE_INDICATOR)[*4]; endsequence
  a_fixed_addr: assert property (
    ADDR_CFG.src == ipl_pkg::SRC_SWITCH |-> ADDR_CFG.addr[31:8] == 24'hC0A801 && ADDR_CFG.mask == 32'hFFFFFF00)
    else $error("fixed address or mask wrong");
  a_switch_static: assert property (
    ADDR_CFG.src == ipl_pkg::SRC_SWITCH |-> !ADDR_CFG.dhcp_active && !DHCP_REQUEST) else $error("dhcp on with switch");
  a_link_colour: assert property (
    !$past(SYS_RST) && $past(FIRST_ETHERNET_PORT.link) && !$past(FIRST_ETHERNET_PORT.activity)
    |-> PORT1_LINK_ACTIVITY_INDICATOR == {1'b1, !$past(FIRST_ETHERNET_PORT.fast)}) else $error("link colour wrong");
  a_link_off: assert property (
    !$past(SYS_RST) && !$past(FIRST_ETHERNET_PORT.link) |-> PORT1_LINK_ACTIVITY_INDICATOR == 2'b00)
    else $error("link lamp lit without link");
  a_ms_major: assert property (
    run_s ##0 $past(MAJOR_FAULT) |-> MODULE_STATE_INDICATOR == 2'b01) else $error("major fault not red");
  a_ns_conflict: assert property (
    run_s ##0 (ADDR_CFG.valid && $past(ADDR_CONFLICT)) |-> NETWORK_STATE_INDICATOR == 2'b01)
    else $error("address clash not red");
  a_selftest_alt: assert property (
    $fell(SYS_RST) |-> ##2 alt_s) else $error("self-test lamps wrong");
  a_start_wait: assert property (
    $fell(SYS_RST) |-> (!NET_START)[*8]) else $error("network start before self-test end");
endmodule // ipl_properties

bind ipl_top ipl_properties u_props (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .MAJOR_FAULT(MAJOR_FAULT), .ADDR_CONFLICT(ADDR_CONFLICT),
  .FIRST_ETHERNET_PORT(FIRST_ETHERNET_PORT), .ADDR_CFG(ADDR_CFG), .DHCP_REQUEST(DHCP_REQUEST),
  .NET_START(NET_START), .MODULE_STATE_INDICATOR(MODULE_STATE_INDICATOR),
  .NETWORK_STATE_INDICATOR(NETWORK_STATE_INDICATOR), .PORT1_LINK_ACTIVITY_INDICATOR(PORT1_LINK_ACTIVITY_INDICATOR));

/* tb/ipl_partner.sv */
// Behavioural DHCP server and scanner on the network side
`timescale 1ns/10ps
module ipl_partner #(
  parameter logic [31:0] LEASE = 32'h0A00002A  // Address handed out
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // Bench controls
  input  wire logic   slow,
  input  wire logic   scan_go,
  // Block side
  input  wire logic   dhcp_request,
  output logic        dhcp_done,
  output logic [31:0] dhcp_addr,
  output logic [31:0] dhcp_mask,
  output logic        scan_set
);
  logic [3:0] wait_cnt;  // Cycles the request has waited
  // Junk outside the answer cycle, so a late read shows
  assign dhcp_addr = dhcp_done ? LEASE : ~LEASE;
  assign dhcp_mask = dhcp_done ? 32'hFFFFFF00 : 32'h000000FF;
  // Answer a pending request promptly or slowly
  always_ff @(posedge clk) begin
    scan_set <= scan_go;
    dhcp_done <= 1'b0;
    if (rst || !dhcp_request || dhcp_done) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt == (slow ? 4'hC : 4'h2)) begin
      dhcp_done <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // ipl_partner

/* tb/tb_top.sv */
// Self-checking bench for the address select and indicator block
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] LEASE = 32'h0A00002A;
  localparam logic [31:0] NET_ADDR = 32'h0A000007;
  localparam logic [7:0] FIXED [3] = '{8'h01, 8'h81, 8'hFE};
  logic clk = 1'b0, rst = 1'b1, web_set = 1'b0, scan_go = 1'b0, slow = 1'b0;
  logic configured = 1'b0, major = 1'b0, conflict = 1'b0, conn_up = 1'b0;
  logic dhcp_done, scan_set, dhcp_req, net_start;
  logic [7:0] sw = 8'h00;
  logic [31:0] dhcp_addr, dhcp_mask, set_addr = 32'h0, set_mask = 32'h0;
  ipl_pkg::ipl_port_t port1 = 3'h0, port2 = 3'h0;
  ipl_pkg::ipl_addr_t cfg;
  ipl_pkg::ipl_led_t ms, ns, p1, p2;
  int failures = 0, samples_checked = 0;
  always #25 clk = ~clk;
  ipl_top #(.SLOW_CYCLES(4), .FAST_CYCLES(2), .SELFTEST_CYCLES(8)) dut (.CLK_SYS(clk), .SYS_RST(rst),
    .ADDR_SWITCH(sw), .DHCP_DONE(dhcp_done), .DHCP_ADDR(dhcp_addr), .DHCP_MASK(dhcp_mask), .SCANNER_SET(scan_set),
    .WEB_SET(web_set), .SET_ADDR(set_addr), .SET_MASK(set_mask), .CONFIGURED(configured), .MINOR_FAULT(1'b0),
    .MAJOR_FAULT(major), .CONN_UP(conn_up), .CONN_LOST(1'b0), .ADDR_CONFLICT(conflict),
    .FIRST_ETHERNET_PORT(port1), .SECOND_ETHERNET_PORT(port2), .ADDR_CFG(cfg), .DHCP_REQUEST(dhcp_req),
    .NET_START(net_start), .MODULE_STATE_INDICATOR(ms), .NETWORK_STATE_INDICATOR(ns),
    .PORT1_LINK_ACTIVITY_INDICATOR(p1), .PORT2_LINK_ACTIVITY_INDICATOR(p2));
  ipl_partner #(.LEASE(LEASE)) far (.clk(clk), .rst(rst), .slow(slow), .scan_go(scan_go),
    .dhcp_request(dhcp_req), .dhcp_done(dhcp_done), .dhcp_addr(dhcp_addr), .dhcp_mask(dhcp_mask), .scan_set(scan_set));
  task automatic cmp_val(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_led(string what, ipl_pkg::ipl_led_t exp, ipl_pkg::ipl_led_t got);
    cmp_val(what, {30'h0, exp}, {30'h0, got});
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  // Reset, then move the switch once it has been taken
  task automatic boot(logic [7:0] val);
    rst <= 1'b1;
    sw <= val;
    tick(10);
    rst <= 1'b0;
    tick(1);
    sw <= ~val;
    for (int i = 0; i < 40 && net_start !== 1'b1; i++) tick(1);
    tick(3);
    cmp_val("net_start", 32'h1, {31'h0, net_start});
  endtask
  // One address push by web or scanner
  task automatic push(logic web);
    set_addr <= NET_ADDR;
    set_mask <= 32'hFFFF0000;
    web_set <= web;
    scan_go <= !web;
    tick(1);
    web_set <= 1'b0;
    scan_go <= 1'b0;
    tick(4);
  endtask
  task automatic wait_valid;
    for (int i = 0; i < 40 && cfg.valid !== 1'b1; i++) tick(1);
    tick(2);
  endtask
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    int lit;
    int dark;
    lit = 0;
    dark = 0;
    foreach (FIXED[i]) begin
      boot(FIXED[i]);
      push(1'b1);
      cmp_val("addr", {ipl_pkg::FIXED_PREFIX, FIXED[i]}, cfg.addr);
      cmp_val("mask", 32'hFFFFFF00, cfg.mask);
      cmp_val("dhcp", 32'h0, {30'h0, cfg.dhcp_active, dhcp_req});
    end
    configured <= 1'b1;
    conn_up <= 1'b1;
    port1 <= 3'b110;
    port2 <= 3'b100;
    tick(3);
    cmp_led("ms", 2'b10, ms);
    cmp_led("ns", 2'b10, ns);
    cmp_led("p1", 2'b10, p1);
    cmp_led("p2", 2'b11, p2);
    major <= 1'b1;
    conflict <= 1'b1;
    port1 <= 3'b000;
    port2 <= 3'b101;
    for (int i = 0; i < 8; i++) begin
      tick(1);
      lit += (p2 === 2'b11);
      dark += (p2 === 2'b00);
    end
    cmp_val("p2 blink", 32'h1, {31'h0, lit > 0 && dark > 0 && lit + dark == 8});
    cmp_led("ms", 2'b01, ms);
    cmp_led("ns", 2'b01, ns);
    cmp_led("p1", 2'b00, p1);
    major <= 1'b0;
    conflict <= 1'b0;
    slow <= 1'b1;
    boot(8'h00);
    cmp_val("wait", 32'h3, {30'h0, cfg.dhcp_active, dhcp_req});
    cmp_led("ns", 2'b00, ns);
    wait_valid;
    cmp_val("lease", LEASE, cfg.addr);
    push(1'b0);
    cmp_val("stored", NET_ADDR, cfg.addr);
    slow <= 1'b0;
    boot(8'hFF);
    push(1'b1);
    push(1'b0);
    wait_valid;
    cmp_val("forced", LEASE, cfg.addr);
    cmp_val("dhcp on", 32'h1, {31'h0, cfg.dhcp_active});
    end_of_test;
  end
  // Hang guard
  initial begin
    #(2000 * 50);
    failures++;
    end_of_test;
  end
endmodule // tb_top
